// ### bench/bridge_gate_model.sv
// Purpose: Gate discharge indications of the four half-bridge stages.
// Assumes: A gate reads off some cycles after its command drops.
// Notes: The slow input stretches the discharge to three cycles.
`timescale 1ns/10ps
module bridge_gate_model
import hb_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire hb_ctrl_pkg::gate_drive_type gate_drive,
    input wire logic slow,
    output logic [hb_ctrl_pkg::NUM_BRIDGES-1:0] high_gate_off,
    output logic [hb_ctrl_pkg::NUM_BRIDGES-1:0] low_gate_off
);
    logic [11:0] hi_r, lo_r;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hi_r <= '0;
            lo_r <= '0;
        end else begin
            hi_r <= {hi_r[7:0], gate_drive.high_on};
            lo_r <= {lo_r[7:0], gate_drive.low_on};
        end
    end
    // A gate that is commanded on never reads off, so a hasty turn-on of the other side shows at once.
    assign high_gate_off = ~(gate_drive.high_on | hi_r[3:0] | (slow ? hi_r[7:4] | hi_r[11:8] : 4'h0));
    assign low_gate_off = ~(gate_drive.low_on | lo_r[3:0] | (slow ? lo_r[7:4] | lo_r[11:8] : 4'h0));
endmodule // bridge_gate_model

// ### bench/hb_ctrl_checker.sv
// Purpose: Port-level assertions for the sensor, wake and half-bridge block.
// Assumes: Sees only the top module's ports.
// Notes: Pin timing allows for the two-flop synchronisers.
`timescale 1ns/10ps
module hb_ctrl_checker
import hb_ctrl_pkg::*;
#(parameter int NUM_HB = 4)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire hb_ctrl_pkg::reg_req_type reg_req,
    input wire logic [hb_ctrl_pkg::DATA_W-1:0] reg_rdata,
    input wire hb_ctrl_pkg::power_mode_type power_mode,
    input wire logic wake_input_pin,
    input wire logic [NUM_HB-1:0] high_gate_off,
    input wire logic [NUM_HB-1:0] low_gate_off,
    input wire hb_ctrl_pkg::gate_drive_type gate_drive,
    input wire logic sensor_irq,
    input wire logic wake_irq,
    input wire logic wake_request
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Counts quiet cycles on the wake pin, so a read is only judged once the synchroniser has settled.
    logic [3:0] wake_stable_r;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wake_stable_r <= 4'h0;
        end else if ($changed(wake_input_pin)) begin
            wake_stable_r <= 4'h0;
        end else if (wake_stable_r != 4'hF) begin
            wake_stable_r <= wake_stable_r + 4'h1;
        end
    end
    AST_NO_SHOOT: assert property ((gate_drive.high_on & gate_drive.low_on) == '0)
        else $error("Both sides of a bridge are on.");
    AST_HIGH_WAITS: assert property ((gate_drive.high_on & ~$past(gate_drive.high_on)
        & ~$past(low_gate_off)) == '0)
        else $error("High side turned on before low gate was off.");
    AST_LOW_WAITS: assert property ((gate_drive.low_on & ~$past(gate_drive.low_on)
        & ~$past(high_gate_off)) == '0)
        else $error("Low side turned on before high gate was off.");
    AST_SENSOR_IRQ_RUN: assert property ($rose(sensor_irq) |-> ($past(power_mode, 1) == MODE_RUN
        || $past(power_mode, 2) == MODE_RUN || $past(power_mode, 3) == MODE_RUN))
        else $error("Sensor interrupt raised outside run mode.");
    AST_WAKE_IRQ_RUN: assert property ($rose(wake_irq) |-> ($past(power_mode, 1) == MODE_RUN
        || $past(power_mode, 2) == MODE_RUN || $past(power_mode, 3) == MODE_RUN))
        else $error("Wake interrupt raised outside run mode.");
    AST_WAKE_REQ_RUN: assert property (power_mode == MODE_RUN |=> !wake_request)
        else $error("Wake request held in run mode.");
    AST_WAKE_DETECT: assert property ((power_mode != MODE_RUN) [*6] ##0 $changed(wake_input_pin)
        |-> ##[1:5] (wake_request || power_mode == MODE_RUN))
        else $error("Wake pin change in low power gave no wake request.");
    AST_WAKE_STATE: assert property (reg_req.rd && reg_req.addr == ADDR_SENSOR_WAKE && wake_stable_r > 4'h4
        |=> reg_rdata[SW_WAKE_STATE_BIT] == $past(wake_input_pin))
        else $error("Wake state bit differs from pin.");
endmodule // hb_ctrl_checker
bind hall_input_halfbridge_ctrl hb_ctrl_checker #(.NUM_HB(NUM_HB)) i_chk (.ref_clk, .rstn, .reg_req, .reg_rdata,
    .power_mode, .wake_input_pin, .high_gate_off, .low_gate_off, .gate_drive, .sensor_irq, .wake_irq, .wake_request);

// ### bench/test_hall_input_halfbridge_ctrl.sv
// Purpose: Self-checking bench for the sensor, wake and half-bridge block.
// Assumes: Gate-off indications come from the load model.
// Notes: Bridge settings and PWM levels come from a bench LFSR.
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_hall_input_halfbridge_ctrl;
    import hb_ctrl_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    reg_req_type req = '0;
    power_mode_type mode = MODE_RUN;
    logic s_pin = 1'b1, s_oc = 1'b0, w_pin = 1'b0, pwm = 1'b0, slow = 1'b0;
    logic [3:0] hgo, lgo;
    gate_drive_type gd;
    logic [7:0] reg_rdata, rdata, cfg;
    logic hall, pu, port, sense_amplification_select, s_irq, w_irq, w_req, on, recirculation_mode_select;
    logic [31:0] lfsr = 32'hCFC3;
    int errors = 0, checks = 0, cyc = 0;
    hall_input_halfbridge_ctrl #(.NUM_HB(4)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_req(req),
        .reg_rdata(reg_rdata), .power_mode(mode), .sensor_input_pin(s_pin), .sensor_overcurrent(s_oc),
        .wake_input_pin(w_pin), .pwm_in(pwm), .high_gate_off(hgo), .low_gate_off(lgo), .gate_drive(gd),
        .sensor_hall_mode(hall), .sensor_pullup_on(pu), .sensor_port_on(port), .sense_amp_low_res(sense_amplification_select),
        .sensor_irq(s_irq), .wake_irq(w_irq), .wake_request(w_req));
    bridge_gate_model i_load (.ref_clk(ref_clk), .rstn(rstn), .gate_drive(gd), .slow(slow),
        .high_gate_off(hgo), .low_gate_off(lgo));
    initial forever #10 ref_clk = ~ref_clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic gate_drive_type exp_gate(input logic [7:0] c, input logic en, rc, p);
        gate_drive_type g;
        g = '0;
        for (int i = 0; i < 4; i++) begin
            g.high_on[i] = en && c[2*i+1] && (!c[2*i] || p);
            g.low_on[i] = en && c[2*i] && (!c[2*i+1] || (rc && !p));
        end
        return g;
    endfunction
    task automatic complete_run();
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 rdata = reg_rdata;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // The ceiling is more than ten times the length of the planned sequence.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        tick(2);
        `CHK({hall, pu, port, sense_amplification_select}, 4'h4)
        for (int i = 0; i < 7; i++) begin
            rd(8'({ADDR_HB_OUT, ADDR_BRIDGE_STATUS, ADDR_SYSTEM_CONTROL, ADDR_IRQ_MASK, ADDR_IRQ_FLAGS,
                ADDR_ANALOG_MUX, 8'h0F} >> (8 * (6 - i))));
            `CHK(rdata, 8'h00)
        end
        rd(ADDR_SENSOR_WAKE);
        `CHK(rdata, 8'h08)
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_SENSOR_WAKE, 8'(k));
            wr(ADDR_ANALOG_MUX, 8'(k << 4));
            tick(1);
            `CHK({hall, pu, port, sense_amplification_select}, {k[0], !k[1], k[0] && k[2], k[0]})
        end
        for (int k = 0; k < 40; k++) begin
            lfsr = lfsr_next(lfsr);
            cfg = (k == 0) ? 8'hFF : lfsr[7:0];
            on = (k % 8 != 7);
            recirculation_mode_select = lfsr[8];
            wr(ADDR_SYSTEM_CONTROL, {7'h00, on});
            wr(ADDR_BRIDGE_STATUS, {recirculation_mode_select, 7'h00});
            wr(ADDR_HB_OUT, cfg);
            @(posedge ref_clk);
            pwm <= lfsr[9];
            slow <= lfsr[10];
            tick(10);
            `CHK(gd, exp_gate(cfg, on, recirculation_mode_select, pwm))
            @(posedge ref_clk);
            pwm <= !pwm;
            tick(10);
            `CHK(gd, exp_gate(cfg, on, recirculation_mode_select, pwm))
            rd(ADDR_HB_OUT);
            `CHK(rdata, cfg)
        end
        wr(ADDR_SENSOR_WAKE, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h03);
        for (int k = 0; k < 6; k++) begin
            wr(ADDR_IRQ_FLAGS, 8'h03);
            @(posedge ref_clk);
            s_pin <= k[0];
            w_pin <= k[1];
            tick(6);
            `CHK({s_irq, w_irq}, {1'b1, k == 2 || k == 4})
            rd(ADDR_SENSOR_WAKE);
            `CHK(rdata[5:3], {k[1], 1'b0, k[0]})
        end
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_IRQ_FLAGS, 8'h03);
        @(posedge ref_clk);
        s_pin <= !s_pin;
        tick(6);
        rd(ADDR_IRQ_FLAGS);
        `CHK({s_irq, rdata[0]}, 2'b01)
        wr(ADDR_IRQ_MASK, 8'h03);
        for (int k = 0; k < 2; k++) begin
            tick(6);
            wr(ADDR_IRQ_FLAGS, 8'h03);
            @(posedge ref_clk);
            mode <= k ? MODE_SLEEP : MODE_STOP;
            repeat (8) @(posedge ref_clk);
            s_pin <= !s_pin;
            w_pin <= !w_pin;
            tick(6);
            `CHK({s_irq, w_irq, w_req}, 3'b001)
            @(posedge ref_clk);
            mode <= MODE_RUN;
            tick(2);
            `CHK(w_req, 1'b0)
        end
        wr(ADDR_SENSOR_WAKE, 8'h05);
        @(posedge ref_clk);
        s_oc <= 1'b1;
        repeat (3) @(posedge ref_clk);
        s_oc <= 1'b0;
        tick(4);
        rd(ADDR_SENSOR_WAKE);
        `CHK(rdata[4], 1'b1)
        wr(ADDR_SENSOR_WAKE, 8'h15);
        rd(ADDR_SENSOR_WAKE);
        `CHK(rdata[4], 1'b0)
        complete_run();
    end
endmodule // test_hall_input_halfbridge_ctrl

// ### core/hall_input_halfbridge_ctrl.sv
// Purpose: Sensor input, wake input and four half-bridge control logic with register port.
// Assumes: Pin levels arrive as inputs; gate-off indications come from the analog stages.
// Notes: One clock domain; pins are resynchronised before any edge logic.
//
// Functional notes
// [R1] Mode bit: 1 selects 2-pin Hall sensing, 0 plain input; reset clears.
// [R2] Pull-up disable bit: 1 disconnects pull-up, 0 keeps it; reset clears.
// [R3] Hall circuitry powered and sensed only while enable bit is 1.
// [R4] Read-only sensor state flag shows sensed level or current below threshold.
// [R5] Over-current in Hall mode sets sticky flag; write 1 or reset clears.
// [R6] In RUN, any change of sensor state sets the sensor interrupt flag.
// [R7] Sensor interrupt works only in RUN, in either input mode.
// [R8] Sensor interrupt forwarded only when its mask enable bit is set.
// [R9] Read-only wake state flag shows current wake input level.
// [R10] In RUN, both wake edges raise an interrupt gated by its enable.
// [R11] Wake level captured entering STOP/SLEEP; a later difference starts wake-up.
// [R12] Reset clears all half-bridge control bits, all stages off.
// [R13] Stages driven only while the general power enable is set.
// [R14] Bit pair decode: off, low on, high on, high side PWM.
// [R15] High and low side of one bridge are never on together.
// [R16] In PWM mode high side follows the external PWM input.
// [R17] Recirculation bit set turns low side on while PWM high side off.
// [R18] Recirculation bit clear keeps low side off; diode freewheels; reset clears.
// [R19] Break-before-make: each side waits until the opposing gate is off.
// [R20] Current-sense gain select: 1 low resolution, 0 high resolution.
// [R21] Sensor and wake inputs pass two-flop synchronisers before edge logic.
// [R22] Pending turn-on held until the opposing gate-off status is asserted.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module hall_input_halfbridge_ctrl #(
    parameter int NUM_HB = hb_ctrl_pkg::NUM_BRIDGES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire hb_ctrl_pkg::reg_req_type reg_req,
    output logic [hb_ctrl_pkg::DATA_W-1:0] reg_rdata,
    input wire hb_ctrl_pkg::power_mode_type power_mode,
    input wire logic sensor_input_pin,
    input wire logic sensor_overcurrent,
    input wire logic wake_input_pin,
    input wire logic pwm_in,
    input wire logic [NUM_HB-1:0] high_gate_off,
    input wire logic [NUM_HB-1:0] low_gate_off,
    output hb_ctrl_pkg::gate_drive_type gate_drive,
    output logic sensor_hall_mode,
    output logic sensor_pullup_on,
    output logic sensor_port_on,
    output logic sense_amp_low_res,
    output logic sensor_irq,
    output logic wake_irq,
    output logic wake_request
);
    import hb_ctrl_pkg::*;

    // ********************************************************
    // Register state
    // ********************************************************
    logic [7:0] hb_out_r;
    logic sensor_mode_select_r;
    logic sensor_pullup_disable_r;
    logic sensor_port_enable_r;
    logic sensor_overcurrent_flag_r;
    logic recirculation_mode_select_r;
    logic power_stage_general_enable_r;
    logic sensor_interrupt_enable_r;
    logic wake_input_interrupt_enable_r;
    logic sensor_interrupt_flag_r;
    logic wake_interrupt_flag_r;
    logic sense_amplification_select_r;
    logic [3:0] mux_source_r;
    logic [1:0] sensor_sync_r;
    logic [1:0] wake_sync_r;
    logic sensor_state_prev_r;
    logic wake_state_prev_r;
    logic wake_captured_r;
    logic low_power_r;
    logic [NUM_HB-1:0] high_on_r;
    logic [NUM_HB-1:0] low_on_r;
    logic sensor_state_flag;
    logic wake_input_state_flag;
    logic is_run;
    logic wr_sw;
    logic wr_if;

    function automatic logic hit(input reg_req_type r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    assign is_run = (power_mode == MODE_RUN);
    assign wr_sw = reg_req.wr && hit(reg_req, ADDR_SENSOR_WAKE);
    assign wr_if = reg_req.wr && hit(reg_req, ADDR_IRQ_FLAGS);

    // ********************************************************
    // Input synchronisers
    // ********************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_sync_r <= 2'h3; // Idles high like the pulled-up pin, so reset gives no false edge.
        end else begin
            sensor_sync_r <= {sensor_sync_r[0], sensor_input_pin}; // [R21]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wake_sync_r <= 2'h0;
        end else begin
            wake_sync_r <= {wake_sync_r[0], wake_input_pin}; // [R21]
        end
    end

    // Disabled Hall port reads as idle high, the pulled-up level.
    assign sensor_state_flag = (sensor_mode_select_r && !sensor_port_enable_r) ? 1'b1 : sensor_sync_r[1]; // [R4]
    assign wake_input_state_flag = wake_sync_r[1]; // [R9]

    // ********************************************************
    // Software-written control bits
    // ********************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hb_out_r <= RESET_BYTE; // [R12]
        end else if (reg_req.wr && hit(reg_req, ADDR_HB_OUT)) begin
            hb_out_r <= reg_req.wdata; // [R14]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_mode_select_r <= 1'b0;
            sensor_pullup_disable_r <= 1'b0;
            sensor_port_enable_r <= 1'b0;
        end else if (wr_sw) begin
            sensor_mode_select_r <= reg_req.wdata[SW_MODE_BIT]; // [R1]
            sensor_pullup_disable_r <= reg_req.wdata[SW_PULLUP_DIS_BIT]; // [R2]
            sensor_port_enable_r <= reg_req.wdata[SW_PORT_EN_BIT]; // [R3]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            recirculation_mode_select_r <= 1'b0; // [R18]
        end else if (reg_req.wr && hit(reg_req, ADDR_BRIDGE_STATUS)) begin
            recirculation_mode_select_r <= reg_req.wdata[BS_RECIRC_BIT]; // [R17] [R18]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            power_stage_general_enable_r <= 1'b0;
        end else if (reg_req.wr && hit(reg_req, ADDR_SYSTEM_CONTROL)) begin
            power_stage_general_enable_r <= reg_req.wdata[SC_POWER_STAGE_GENERAL_ENABLE_BIT]; // [R13]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_interrupt_enable_r <= 1'b0;
            wake_input_interrupt_enable_r <= 1'b0;
        end else if (reg_req.wr && hit(reg_req, ADDR_IRQ_MASK)) begin
            sensor_interrupt_enable_r <= reg_req.wdata[IM_SENSOR_BIT]; // [R8]
            wake_input_interrupt_enable_r <= reg_req.wdata[IM_WAKE_BIT]; // [R10]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sense_amplification_select_r <= 1'b0;
            mux_source_r <= 4'h0;
        end else if (reg_req.wr && hit(reg_req, ADDR_ANALOG_MUX)) begin
            sense_amplification_select_r <= reg_req.wdata[AM_CSA_BIT]; // [R20]
            mux_source_r <= reg_req.wdata[3:0];
        end
    end

    // ********************************************************
    // Sticky flags: a set in the clear cycle wins
    // ********************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_overcurrent_flag_r <= 1'b0;
        end else if (sensor_mode_select_r && sensor_port_enable_r && sensor_overcurrent) begin
            sensor_overcurrent_flag_r <= 1'b1; // [R5]
        end else if (wr_sw && reg_req.wdata[SW_OC_BIT]) begin
            sensor_overcurrent_flag_r <= 1'b0; // [R5]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_state_prev_r <= 1'b1;
        end else begin
            sensor_state_prev_r <= sensor_state_flag; // [R6]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wake_state_prev_r <= 1'b0;
        end else begin
            wake_state_prev_r <= wake_input_state_flag; // [R10]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_interrupt_flag_r <= 1'b0;
        end else if (is_run && (sensor_state_flag != sensor_state_prev_r)) begin
            sensor_interrupt_flag_r <= 1'b1; // [R6] [R7]
        end else if (wr_if && reg_req.wdata[IF_SENSOR_BIT]) begin
            sensor_interrupt_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wake_interrupt_flag_r <= 1'b0;
        end else if (is_run && (wake_input_state_flag != wake_state_prev_r)) begin
            wake_interrupt_flag_r <= 1'b1; // [R10]
        end else if (wr_if && reg_req.wdata[IF_WAKE_BIT]) begin
            wake_interrupt_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_irq <= 1'b0;
        end else begin
            sensor_irq <= sensor_interrupt_flag_r && sensor_interrupt_enable_r; // [R8]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wake_irq <= 1'b0;
        end else begin
            wake_irq <= wake_interrupt_flag_r && wake_input_interrupt_enable_r; // [R10]
        end
    end

    // ********************************************************
    // Low-power wake-up
    // ********************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            low_power_r <= 1'b0;
            wake_captured_r <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            low_power_r <= !is_run;
            if (is_run) begin
                wake_request <= 1'b0;
            end else if (!low_power_r) begin
                wake_captured_r <= wake_input_state_flag; // [R11]
            end else if (wake_input_state_flag != wake_captured_r) begin
                wake_request <= 1'b1; // [R11]
            end
        end
    end

    // ********************************************************
    // Half-bridge drive with break-before-make
    // ********************************************************
    // A request that is blocked stays pending because it is re-evaluated every cycle.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            high_on_r <= '0;
            low_on_r <= '0;
        end else begin
            for (int i = 0; i < NUM_HB; i++) begin
                logic want_high;
                logic want_low;
                bridge_cfg_type cfg;
                want_high = 1'b0;
                want_low = 1'b0;
                cfg = bridge_cfg_type'({hb_out_r[2*i+1], hb_out_r[2*i]});
                case (cfg) // [R14]
                    BR_OFF: ;
                    BR_LOW: want_low = 1'b1;
                    BR_HIGH: want_high = 1'b1;
                    BR_PWM: begin
                        want_high = pwm_in; // [R15] [R16]
                        want_low = !pwm_in && recirculation_mode_select_r; // [R17] [R18]
                    end
                    default: ;
                endcase
                if (!power_stage_general_enable_r) begin
                    want_high = 1'b0; // [R13]
                    want_low = 1'b0; // [R13]
                end
                high_on_r[i] <= want_high && !low_on_r[i] && low_gate_off[i]; // [R19] [R22]
                low_on_r[i] <= want_low && !high_on_r[i] && high_gate_off[i]; // [R19] [R22]
            end
        end
    end

    assign gate_drive.high_on = high_on_r;
    assign gate_drive.low_on = low_on_r;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_hall_mode <= 1'b0;
        end else begin
            sensor_hall_mode <= sensor_mode_select_r; // [R1]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_pullup_on <= 1'b1;
        end else begin
            sensor_pullup_on <= !sensor_pullup_disable_r; // [R2]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_port_on <= 1'b0;
        end else begin
            sensor_port_on <= sensor_mode_select_r && sensor_port_enable_r; // [R3]
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sense_amp_low_res <= 1'b0;
        end else begin
            sense_amp_low_res <= sense_amplification_select_r; // [R20]
        end
    end

    // ********************************************************
    // Read port
    // ********************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_HB_OUT: reg_rdata <= hb_out_r;
                ADDR_SENSOR_WAKE: reg_rdata <= {2'h0, wake_input_state_flag, sensor_overcurrent_flag_r,
                    sensor_state_flag, sensor_port_enable_r, sensor_pullup_disable_r, sensor_mode_select_r};
                ADDR_BRIDGE_STATUS: reg_rdata <= {recirculation_mode_select_r, 7'h00};
                ADDR_SYSTEM_CONTROL: reg_rdata <= {7'h00, power_stage_general_enable_r};
                ADDR_IRQ_MASK: reg_rdata <= {6'h00, wake_input_interrupt_enable_r, sensor_interrupt_enable_r};
                ADDR_IRQ_FLAGS: reg_rdata <= {6'h00, wake_interrupt_flag_r, sensor_interrupt_flag_r};
                ADDR_ANALOG_MUX: reg_rdata <= {3'h0, sense_amplification_select_r, mux_source_r};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // hall_input_halfbridge_ctrl

// ### core/hb_ctrl_pkg.sv
// Purpose: Shared constants and types for the sensor, wake input and half-bridge control block.
// Assumes: Byte-wide registers reached over a plain strobe port.
// Notes: Offsets below the printed ones are coined for bits with no printed home.
package hb_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_BRIDGES = 4;
    // Printed offsets.
    localparam logic [7:0] ADDR_HB_OUT = 8'h01;
    localparam logic [7:0] ADDR_SENSOR_WAKE = 8'h07;
    // Coined offsets.
    localparam logic [7:0] ADDR_BRIDGE_STATUS = 8'h03;
    localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h05;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h06;
    localparam logic [7:0] ADDR_ANALOG_MUX = 8'h08;
    // Sensor/wake register fields.
    localparam int SW_MODE_BIT = 0;
    localparam int SW_PULLUP_DIS_BIT = 1;
    localparam int SW_PORT_EN_BIT = 2;
    localparam int SW_STATE_BIT = 3;
    localparam int SW_OC_BIT = 4;
    localparam int SW_WAKE_STATE_BIT = 5;
    // Other fields.
    localparam int BS_RECIRC_BIT = 7;
    localparam int SC_POWER_STAGE_GENERAL_ENABLE_BIT = 0;
    localparam int IM_SENSOR_BIT = 0;
    localparam int IM_WAKE_BIT = 1;
    localparam int IF_SENSOR_BIT = 0;
    localparam int IF_WAKE_BIT = 1;
    localparam int AM_CSA_BIT = 4;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_STOP = 2'b01,
        MODE_SLEEP = 2'b10
    } power_mode_type;

    typedef enum logic [1:0] {
        BR_OFF = 2'b00,
        BR_LOW = 2'b01,
        BR_HIGH = 2'b10,
        BR_PWM = 2'b11
    } bridge_cfg_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic [NUM_BRIDGES-1:0] high_on;
        logic [NUM_BRIDGES-1:0] low_on;
    } gate_drive_type;
endpackage
